// >>> logic/cvrc_top.sv
// comparator reference control bank with axi4-lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module cvrc_top
    import cvrc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_one_out_pin,
    input wire logic cmp_two_out_pin,
    input wire logic fast_internal_osc,
    input wire logic sleep_active,
    output logic cmp_one_ref_enable,
    output logic cmp_two_ref_enable,
    output logic ladder_range_select,
    output logic [3:0] ladder_tap_value,
    output logic [6:0] ladder_reference_out,
    output logic ladder_at_ground,
    output logic fixed_bandgap_ref,
    output logic cmp_one_on,
    output logic cmp_two_on,
    output logic wake_request,
    output logic vector_branch,
    output logic irq
);
    // ****************************************
    // storage
    // ****************************************
    logic [7:0] ref_reg;
    logic [7:0] cmp1_reg;
    logic [7:0] cmp2_reg;
    logic [7:0] shared_reg;
    logic [7:0] latch_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic global_irq_enable_reg;
    // pin synchroniser and change detector
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] prev_reg;
    // bus holding and answer registers
    logic [13:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ****************************************
    // write channel decode
    // ****************************************
    // only byte lane 0 carries a register; other lanes are ignored
    wire logic do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wire logic wr_lane0 = do_write && wstrb_reg[0];
    wire logic wr_ref = wr_lane0 && awaddr_reg == CVRC_ADDR_REF;
    wire logic wr_cmp1 = wr_lane0 && awaddr_reg == CVRC_ADDR_CMP1;
    wire logic wr_cmp2 = wr_lane0 && awaddr_reg == CVRC_ADDR_CMP2;
    wire logic wr_shared = wr_lane0 && awaddr_reg == CVRC_ADDR_SHARED;
    wire logic wr_latch = wr_lane0 && awaddr_reg == CVRC_ADDR_LATCH;
    wire logic wr_stat = wr_lane0 && awaddr_reg == CVRC_ADDR_IRQ_STAT;
    wire logic wr_mask = wr_lane0 && awaddr_reg == CVRC_ADDR_IRQ_MASK;
    wire logic wr_core = wr_lane0 && awaddr_reg == CVRC_ADDR_CORE;
    wire logic [7:0] wbyte = wdata_reg[7:0];

    // address map check shared by both channels
    function automatic logic addr_known(input logic [13:0] a);
        addr_known = a == CVRC_ADDR_REF || a == CVRC_ADDR_CMP1
            || a == CVRC_ADDR_CMP2 || a == CVRC_ADDR_SHARED
            || a == CVRC_ADDR_LATCH || a == CVRC_ADDR_IRQ_STAT
            || a == CVRC_ADDR_IRQ_MASK || a == CVRC_ADDR_CORE;
    endfunction

    // masked merge: read-only bits keep hardware value
    function automatic logic [7:0] merge(input logic [7:0] old,
        input logic [7:0] nw, input logic [7:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // ****************************************
    // comparator inputs and events
    // ****************************************
    // two stages before any logic sees the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= 2'b00;
            sync2_reg <= 2'b00;
            prev_reg <= 2'b00;
        end
        else
        begin
            sync1_reg <= {cmp_two_out_pin, cmp_one_out_pin};
            sync2_reg <= sync1_reg;
            // delayed copy feeds only the change detector
            prev_reg <= sync2_reg;
        end
    end

    // a change counts only while that comparator is on
    wire logic [1:0] cmp_on = {cmp2_reg[CVRC_B_CMP_ON],
        cmp1_reg[CVRC_B_CMP_ON]};
    wire logic [1:0] cmp_event = (sync2_reg ^ prev_reg) & cmp_on;

    // ****************************************
    // reference and comparator registers
    // ****************************************
    // sleep has no input here: nothing clears on sleep or wake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_reg <= CVRC_RST_REF; // [R3] [R10]
            cmp1_reg <= CVRC_RST_CMP; // [R10]
            cmp2_reg <= CVRC_RST_CMP; // [R10]
            shared_reg <= CVRC_RST_SHARED;
            latch_reg <= CVRC_RST_LATCH;
            global_irq_enable_reg <= 1'b0;
        end
        else
        begin
            // every bit of the reference register is writable
            if (wr_ref)
            begin
                ref_reg <= wbyte; // [R1] [R13] [R6] [R9]
            end
            // output bits mirror the synced pins unless written
            if (wr_cmp1)
            begin
                cmp1_reg <= merge(cmp1_reg, wbyte, CVRC_WMASK_CMP);
            end
            else
            begin
                cmp1_reg[CVRC_B_CMP_OUT] <= sync2_reg[0];
            end
            if (wr_cmp2)
            begin
                cmp2_reg <= merge(cmp2_reg, wbyte, CVRC_WMASK_CMP);
            end
            else
            begin
                cmp2_reg[CVRC_B_CMP_OUT] <= sync2_reg[1];
            end
            // bit 7 mirrors comparator one, bit 6 comparator two
            if (wr_shared)
            begin
                shared_reg <= merge(shared_reg, wbyte, CVRC_WMASK_SHARED);
            end
            else
            begin
                shared_reg[7:6] <= {sync2_reg[0], sync2_reg[1]};
            end
            // bits 7:4 read back the last write; bits 3:0 stay zero
            if (wr_latch)
            begin
                latch_reg <= merge(latch_reg, wbyte, CVRC_WMASK_LATCH);
            end
            if (wr_core)
            begin
                global_irq_enable_reg <= wbyte[CVRC_B_GLOBAL_EN];
            end
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // set wins over a same-cycle write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wbyte[1:0] : 2'b00))
                | cmp_event;
            // mask bits only gate the output, never the status
            if (wr_mask)
            begin
                irq_mask_reg <= wbyte[1:0];
            end
        end
    end

    wire logic irq_pending = |(irq_stat_reg & irq_mask_reg);
    assign irq = irq_pending;
    // wake in sleep; vector taken only with global enable
    assign wake_request = sleep_active && irq_pending; // [R8]
    assign vector_branch = wake_request && global_irq_enable_reg; // [R8]

    // ****************************************
    // analog control outputs
    // ****************************************
    // controls follow the register directly, asleep or awake
    assign cmp_one_ref_enable = ref_reg[CVRC_B_C1REN]; // [R1]
    assign cmp_two_ref_enable = ref_reg[CVRC_B_C2REN]; // [R1]
    assign ladder_range_select = ref_reg[CVRC_B_RANGE]; // [R1]
    assign ladder_tap_value = ref_reg[3:0]; // [R1]
    assign cmp_one_on = cmp_on[0];
    assign cmp_two_on = cmp_on[1];
    // fast oscillator forces the fixed reference on
    assign fixed_bandgap_ref = ref_reg[CVRC_B_FIXED]
        || fast_internal_osc; // [R12]

    // level in 96ths of supply: v/24 = 4v/96, 1/4+v/32 = (24+3v)/96
    wire logic ladder_off = !ref_reg[CVRC_B_C1REN]
        && !ref_reg[CVRC_B_C2REN];
    wire logic [6:0] tap7 = {3'b000, ref_reg[3:0]};
    wire logic [6:0] level_low = 7'(tap7 << 2); // [R2]
    wire logic [6:0] level_high = 7'(CVRC_HIGH_BASE + 7'(tap7 * 7'd3)); // [R2]
    wire logic ground_case = ladder_off && ref_reg[CVRC_B_RANGE]
        && ref_reg[3:0] == 4'h0; // [R11]
    assign ladder_at_ground = ground_case; // [R11]
    assign ladder_reference_out = ground_case ? 7'h00
        : (ref_reg[CVRC_B_RANGE] ? level_low : level_high); // [R2]

    // ****************************************
    // axi4-lite write path
    // ****************************************
    // each ready drops while its half of a write is held
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // address and data latched independently, answered together
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 14'h0000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= CVRC_RESP_OKAY;
        end
        else
        begin
            // address half
            if (s_axi_awvalid && !aw_held_reg)
            begin
                awaddr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end
            // data half
            if (s_axi_wvalid && !w_held_reg)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
            end
            // both halves held: apply and answer
            if (do_write)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= addr_known(awaddr_reg) ? CVRC_RESP_OKAY
                    : CVRC_RESP_SLVERR;
            end
            // answer taken: free both halves
            if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // axi4-lite read path
    // ****************************************
    // reads have no side effects on any register
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            CVRC_ADDR_REF: rd_byte = ref_reg; // [R13]
            CVRC_ADDR_CMP1: rd_byte = cmp1_reg;
            CVRC_ADDR_CMP2: rd_byte = cmp2_reg;
            CVRC_ADDR_SHARED: rd_byte = shared_reg;
            CVRC_ADDR_LATCH: rd_byte = latch_reg;
            CVRC_ADDR_IRQ_STAT: rd_byte = {6'h00, irq_stat_reg};
            CVRC_ADDR_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
            CVRC_ADDR_CORE: rd_byte = {global_irq_enable_reg, 7'h00};
            default: rd_byte = 8'h00;
        endcase
    end

    // no new address while an answer waits
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= CVRC_RESP_OKAY;
        end
        // address taken and answered at the same edge
        else if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, rd_byte};
            rresp_reg <= addr_known(s_axi_araddr) ? CVRC_RESP_OKAY
                : CVRC_RESP_SLVERR;
        end
        // answer taken: the next address may follow
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> logic/cvrc_pkg.sv
// package of constants for the comparator reference control bank
// How it works
// [R1] reference register: enables, range, fixed, tap
// [R2] tap selects ladder level per range
// [R3] reference register resets to zero
// [R4] software waits settling after enabling reference
// [R5] software waits response time after changes
// [R6] enabled blocks keep running through sleep
// [R7] software clears enables before sleep
// [R8] comparator interrupt wakes; vector if enabled
// [R9] wake leaves control registers unchanged
// [R10] reset restores comparator and reference registers
// [R11] disabled, range set, tap zero: ground
// [R12] fixed reference forced on with fast oscillator
// [R13] reference register reads back last write
package cvrc_pkg;
    // ****************************************
    // register byte offsets (printed index x4)
    // ****************************************
    localparam logic [11:0] CVRC_IDX_REF = 12'h118;
    localparam logic [11:0] CVRC_IDX_CMP1 = 12'h119;
    localparam logic [11:0] CVRC_IDX_CMP2 = 12'h11a;
    localparam logic [11:0] CVRC_IDX_SHARED = 12'h11b;
    localparam logic [11:0] CVRC_IDX_LATCH = 12'h19e;
    localparam logic [13:0] CVRC_ADDR_REF = {CVRC_IDX_REF, 2'b00};
    localparam logic [13:0] CVRC_ADDR_CMP1 = {CVRC_IDX_CMP1, 2'b00};
    localparam logic [13:0] CVRC_ADDR_CMP2 = {CVRC_IDX_CMP2, 2'b00};
    localparam logic [13:0] CVRC_ADDR_SHARED = {CVRC_IDX_SHARED, 2'b00};
    localparam logic [13:0] CVRC_ADDR_LATCH = {CVRC_IDX_LATCH, 2'b00};
    localparam logic [13:0] CVRC_ADDR_IRQ_STAT = 14'h0800;
    localparam logic [13:0] CVRC_ADDR_IRQ_MASK = 14'h0804;
    localparam logic [13:0] CVRC_ADDR_CORE = 14'h0808;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CVRC_B_C1REN = 7;
    localparam int CVRC_B_C2REN = 6;
    localparam int CVRC_B_RANGE = 5;
    localparam int CVRC_B_FIXED = 4;
    localparam int CVRC_B_CMP_ON = 7;
    localparam int CVRC_B_CMP_OUT = 6;
    localparam int CVRC_B_GLOBAL_EN = 7;
    // irq status bits: 0 cmp one change, 1 cmp two change
    localparam int CVRC_B_IRQ1 = 0;
    localparam int CVRC_B_IRQ2 = 1;
    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [7:0] CVRC_RST_REF = 8'h00;
    localparam logic [7:0] CVRC_RST_CMP = 8'h00;
    localparam logic [7:0] CVRC_RST_SHARED = 8'h02;
    localparam logic [7:0] CVRC_RST_LATCH = 8'h00;
    localparam logic [7:0] CVRC_WMASK_CMP = 8'hb7;
    localparam logic [7:0] CVRC_WMASK_SHARED = 8'h03;
    localparam logic [7:0] CVRC_WMASK_LATCH = 8'hf0;
    localparam logic [1:0] CVRC_RESP_OKAY = 2'b00;
    localparam logic [1:0] CVRC_RESP_SLVERR = 2'b10;
    // ladder level in 1/96 of supply: low 4*v, high 24+3*v
    localparam logic [6:0] CVRC_HIGH_BASE = 7'h18;
endpackage

// >>> dv/cvrc_asserts.sv
// assertion checker for the comparator reference control bank
`timescale 1ns/10ps
`default_nettype none
module cvrc_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic cmp_one_ref_enable,
    input wire logic cmp_two_ref_enable,
    input wire logic ladder_range_select,
    input wire logic [3:0] ladder_tap_value,
    input wire logic [6:0] ladder_reference_out,
    input wire logic ladder_at_ground,
    input wire logic fixed_bandgap_ref,
    input wire logic fast_internal_osc,
    input wire logic sleep_active,
    input wire logic cmp_one_on,
    input wire logic irq,
    input wire logic wake_request,
    input wire logic vector_branch
);
    // ****************************************
    // output relations, levels in 96ths
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_low_range: assert property (ladder_range_select |->
        ladder_reference_out == {1'b0, ladder_tap_value, 2'b00})
        else $error("low range level wrong");
    chk_high_range: assert property (!ladder_range_select |->
        ladder_reference_out == 7'h18 + {3'h0, ladder_tap_value} * 7'h03)
        else $error("high range level wrong");
    chk_ground_flag: assert property (ladder_at_ground ==
        (!cmp_one_ref_enable && !cmp_two_ref_enable && ladder_range_select
        && ladder_tap_value == 4'h0))
        else $error("ground flag wrong");
    chk_fixed_forced: assert property (fast_internal_osc |->
        fixed_bandgap_ref) else $error("fixed ref not forced");
    chk_wake_level: assert property (wake_request ==
        (sleep_active && irq)) else $error("wake request wrong");
    chk_vector_gated: assert property (vector_branch |->
        wake_request) else $error("branch without wake");
    // reset edge already cleared everything before release
    chk_reset_state: assert property ($rose(aresetn) |->
        !cmp_one_ref_enable && !cmp_two_ref_enable && !ladder_range_select
        && ladder_tap_value == 4'h0 && !cmp_one_on
        && fixed_bandgap_ref == fast_internal_osc)
        else $error("reset state wrong");
    // a write shows bvalid the cycle its value lands, so exclude those
    chk_sleep_hold: assert property (sleep_active
        && $past(sleep_active) && $past(aresetn) && !s_axi_bvalid
        |-> $stable({cmp_one_ref_enable, cmp_two_ref_enable,
        ladder_range_select, ladder_tap_value, cmp_one_on}))
        else $error("sleep altered controls");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("bvalid dropped early");
endmodule
bind cvrc_top cvrc_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .cmp_one_ref_enable(cmp_one_ref_enable),
    .cmp_two_ref_enable(cmp_two_ref_enable),
    .ladder_range_select(ladder_range_select),
    .ladder_tap_value(ladder_tap_value),
    .ladder_reference_out(ladder_reference_out),
    .ladder_at_ground(ladder_at_ground),
    .fixed_bandgap_ref(fixed_bandgap_ref),
    .fast_internal_osc(fast_internal_osc), .sleep_active(sleep_active),
    .cmp_one_on(cmp_one_on), .irq(irq), .wake_request(wake_request),
    .vector_branch(vector_branch));
`default_nettype wire

// >>> dv/tb.sv
// self-checking testbench for the comparator reference control bank
`timescale 1ns/10ps
`default_nettype none
module tb
    import cvrc_pkg::*;
;
    logic aclk, aresetn, pin1, pin2, osc, sleep;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, tap;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, en1, en2, rng, gnd, fix;
    logic on1, on2, wake, vec, irq;
    logic [6:0] lvl;
    int miscompares, check_count, i;
    cvrc_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cmp_one_out_pin(pin1),
        .cmp_two_out_pin(pin2), .fast_internal_osc(osc),
        .sleep_active(sleep), .cmp_one_ref_enable(en1),
        .cmp_two_ref_enable(en2), .ladder_range_select(rng),
        .ladder_tap_value(tap), .ladder_reference_out(lvl),
        .ladder_at_ground(gnd), .fixed_bandgap_ref(fix), .cmp_one_on(on1),
        .cmp_two_on(on2), .wake_request(wake), .vector_branch(vec),
        .irq(irq));
    // ****************************************
    // clock, bus tasks, compare and verdict
    // ****************************************
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // handshakes sampled at negedge so the decision never races the edge
    task automatic wr(input logic [13:0] a, input logic [7:0] v,
        output logic [1:0] rs);
        logic aw, w, b;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (b)
                s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [13:0] a, output logic [31:0] v,
        output logic [1:0] rs);
        logic ar, t;
        t = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!t)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            t = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar)
                s_axi_arvalid <= 1'b0;
            if (t)
                s_axi_rready <= 1'b0;
        end
    endtask
    task automatic rchk(input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk(v, exp);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // run length is about four hundred cycles, so allow fifty times that
    initial
    begin
        #160000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude;
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, pin1, pin2, osc, sleep} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
        s_axi_wstrb = 4'h1;
        miscompares = 0;
        check_count = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(CVRC_ADDR_REF, 32'h00);
        rchk(CVRC_ADDR_CMP1, 32'h00);
        rchk(CVRC_ADDR_CMP2, 32'h00);
        rchk(CVRC_ADDR_SHARED, 32'h02);
        rchk(CVRC_ADDR_LATCH, 32'h00);
        $display("test reset_values done");
        // every tap in both ranges, enables and fixed bit varied
        for (i = 0; i < 32; i++)
        begin
            d = {24'h0, i[0], i[1], i[4], i[2], i[3:0]};
            wr(CVRC_ADDR_REF, d[7:0], r);
            chk(32'(lvl), i[4] ? 4 * (i % 16) : 24 + 3 * (i % 16));
            chk(32'({en1, en2, rng, fix, tap}), d);
            chk(32'(gnd), 32'(d[7:0] == 8'h20));
            rchk(CVRC_ADDR_REF, d);
        end
        osc <= 1'b1;
        wr(CVRC_ADDR_REF, 8'h00, r);
        chk(32'(fix), 32'h1);
        osc <= 1'b0;
        rd(14'h0010, d, r);
        chk(32'(r), 32'(CVRC_RESP_SLVERR));
        chk(d, 32'h0);
        wr(14'h0010, 8'hff, r);
        chk(32'(r), 32'(CVRC_RESP_SLVERR));
        wr(CVRC_ADDR_LATCH, 8'hff, r);
        rchk(CVRC_ADDR_LATCH, 32'hf0);
        $display("test ladder_map done");
        wr(CVRC_ADDR_REF, 8'hc5, r);
        chk(32'(r), 32'(CVRC_RESP_OKAY));
        repeat (8) @(posedge aclk);
        wr(CVRC_ADDR_CMP1, 8'h80, r);
        wr(CVRC_ADDR_CMP2, 8'hff, r);
        rchk(CVRC_ADDR_CMP2, 32'hb7);
        chk(32'(on2), 32'h1);
        wr(CVRC_ADDR_IRQ_MASK, 8'h01, r);
        pin1 <= 1'b1;
        for (i = 0; i < 10 && irq !== 1'b1; i++)
            @(negedge aclk);
        chk(32'({on1, irq}), 32'h3);
        @(posedge aclk);
        sleep <= 1'b1;
        @(negedge aclk);
        chk(32'({wake, vec}), 32'h2);
        wr(CVRC_ADDR_CORE, 8'h80, r);
        chk(32'(vec), 32'h1);
        repeat (20) @(posedge aclk);
        rchk(CVRC_ADDR_REF, 32'hc5);
        rchk(CVRC_ADDR_CMP1, 32'hc0);
        rchk(CVRC_ADDR_CMP2, 32'hb7);
        chk(32'({en1, en2, on1, on2}), 32'hf);
        sleep <= 1'b0;
        rchk(CVRC_ADDR_SHARED, 32'h82);
        wr(CVRC_ADDR_IRQ_MASK, 8'h00, r);
        chk(32'({irq, wake}), 32'h0);
        wr(CVRC_ADDR_IRQ_MASK, 8'h01, r);
        chk(32'(irq), 32'h1);
        wr(CVRC_ADDR_IRQ_STAT, 8'h01, r);
        chk(32'(irq), 32'h0);
        rchk(CVRC_ADDR_IRQ_STAT, 32'h0);
        // masked comparator two change is recorded but stays quiet
        pin2 <= 1'b1;
        repeat (4) @(posedge aclk);
        rchk(CVRC_ADDR_IRQ_STAT, 32'h2);
        chk(32'(irq), 32'h0);
        // low power sleep: comparators and ladder off first
        wr(CVRC_ADDR_CMP1, 8'h00, r);
        wr(CVRC_ADDR_CMP2, 8'h00, r);
        wr(CVRC_ADDR_REF, 8'h00, r);
        sleep <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(32'({en1, en2, on1, on2, wake}), 32'h0);
        sleep <= 1'b0;
        $display("test irq_sleep done");
        wr(CVRC_ADDR_REF, 8'hd3, r);
        wr(CVRC_ADDR_CMP2, 8'h80, r);
        wr(CVRC_ADDR_CORE, 8'h80, r);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(CVRC_ADDR_REF, 32'h00);
        chk(32'({en1, en2, on1, on2, irq}), 32'h0);
        rchk(CVRC_ADDR_CORE, 32'h00);
        $display("test mid_reset done");
        conclude;
    end
endmodule
`default_nettype wire
